// ==== include/lpf_map.vh ====
/*
  Constants of the link framer: frame octets, check sequence values,
  path label codes, register offsets, reset values and timing.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef LPF_MAP_VH
`define LPF_MAP_VH
`define LPF_FLAG 8'h7E
`define LPF_ESC 8'h7D
`define LPF_ESC_XOR 8'h20
`define LPF_ADDR 8'h04
`define LPF_CTRL_UI 8'h03
`define LPF_SPI_HI 8'h00
`define LPF_SPI_V4 8'h21
`define LPF_SPI_V6 8'h57
`define LPF_MIN_OCTETS 16'h0006
`define LPF_CRC_POLY 32'hEDB88320
`define LPF_CRC_INIT 32'hFFFFFFFF
`define LPF_CRC_GOOD 32'hDEBB20E3
`define LPF_LABEL_SCR 8'h18
`define LPF_LABEL_COMPAT 8'h16
`define LPF_LABEL_PLAIN 8'hCF
`define LPF_SCR_LEN 43
`define LPF_REG_CTRL 4'h0
`define LPF_REG_TIMER 4'h1
`define LPF_REG_RETRY 4'h2
`define LPF_REG_STATUS 4'h3
`define LPF_REG_GOOD 4'h4
`define LPF_REG_DROP 4'h5
`define LPF_REG_LABEL 4'h6
`define LPF_CTRL_SCR_BIT 0
`define LPF_CTRL_LOWVC_BIT 1
`define LPF_CTRL_MODE_LSB 2
`define LPF_CTRL_MON_BIT 4
`define LPF_CTRL_RST 5'h11
`define LPF_TIMER_RST 8'h0A
`define LPF_RETRY_RST 8'h03
`define LPF_TICK_MS 100
`define LPF_CLK_KHZ 200000
`define LPF_TICK_CYC (`LPF_TICK_MS * `LPF_CLK_KHZ)
`endif

// ==== logic/lpf_scrambler.v ====
/*
  Byte-wide self-synchronous scrambler or descrambler, one octet per strobe.
  Assumes strobes come at most once a cycle; output is registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpf_map.vh"
module lpf_scrambler #(
  parameter DESCR = 0
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_en,
  input wire i_bypass,
  input wire [7:0] i_data,
  output reg o_valid,
  output reg [7:0] o_data
);
  reg [`LPF_SCR_LEN-1:0] hist_q;
  reg [`LPF_SCR_LEN-1:0] hist_d;
  reg [7:0] out_d;
  integer i;

  // Most significant bit goes first; the history holds line-side bits.
  always @*
  begin
    hist_d = hist_q;
    out_d = 8'h00;
    for (i = 7; i >= 0; i = i - 1)
    begin
      out_d[i] = i_data[i] ^ hist_d[`LPF_SCR_LEN-1]; // RULE_18 RULE_19
      hist_d = {hist_d[`LPF_SCR_LEN-2:0],
                (DESCR != 0) ? i_data[i] : out_d[i]}; // RULE_27
    end
  end

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      hist_q <= {`LPF_SCR_LEN{1'b0}};
      o_valid <= 1'b0;
      o_data <= 8'h00;
    end
    else
    begin
      o_valid <= i_en;
      if (i_en)
      begin
        hist_q <= hist_d;
        o_data <= i_bypass ? i_data : out_d; // RULE_20
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/lpf_silence_mon.v ====
/*
  Idle-link monitor: silence timer in 100 ms steps and a retry count.
  Assumes i_activity pulses for every received octet.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpf_map.vh"
module lpf_silence_mon #(
  parameter TICK_CYC = `LPF_TICK_CYC
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_enable,
  input wire i_activity,
  input wire [7:0] i_period,
  input wire [7:0] i_retries,
  output reg o_link_loss
);
  reg [31:0] tick_cnt_q;
  reg [7:0] per_cnt_q;
  reg [7:0] retry_q;
  wire tick = (tick_cnt_q == TICK_CYC - 1);
  wire expire = tick && (per_cnt_q + 8'h01 >= i_period);

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt_q <= 32'h00000000;
      per_cnt_q <= 8'h00;
      retry_q <= `LPF_RETRY_RST; // RULE_14
      o_link_loss <= 1'b0;
    end
    else
    begin
      o_link_loss <= 1'b0;
      if (!i_enable || i_activity)
      begin
        tick_cnt_q <= 32'h00000000; // RULE_28
        per_cnt_q <= 8'h00;
        retry_q <= i_retries;
      end
      else
      begin
        tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
        if (expire)
        begin
          per_cnt_q <= 8'h00; // RULE_17
          if (retry_q == 8'h00)
          begin
            o_link_loss <= 1'b1; // RULE_16
            retry_q <= i_retries;
          end
          else
            retry_q <= retry_q - 8'h01; // RULE_15
        end
        else if (tick)
          per_cnt_q <= per_cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/lpf_framer.v ====
/*
  Octet link framer: builds unnumbered information frames from upper data,
  escapes, checks and scrambles them; on receive it descrambles, removes
  escapes, validates and delivers good information fields upward.
  Assumes the path framer pulls one octet per i_line_tx_req strobe and
  offers received octets with i_line_rx_valid, all on i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpf_map.vh"
// Behaviour
// RULE_01 - Single-octet fields: bit one is LSB
// RULE_02 - Multi-octet fields: earlier octets carry higher bits
// RULE_03 - Check sequence sent least significant octet first
// RULE_04 - Drop frames not bounded by two flags
// RULE_05 - Drop frames shorter than six octets
// RULE_06 - Drop frames with check sequence mismatch
// RULE_07 - Drop frames with unsupported service point
// RULE_08 - Drop frames with unknown control octet
// RULE_09 - Invalid frames vanish silently
// RULE_10 - Service point field is two octets
// RULE_11 - 0021 is IPv4, 0057 is IPv6
// RULE_12 - Each upper packet becomes one frame
// RULE_13 - Deliver information field of supported frames
// RULE_14 - Monitor defaults: one second, three retries
// RULE_15 - Silence expiry restarts timer, decrements retries
// RULE_16 - Expiry at zero retries signals link loss
// RULE_17 - Timer in 100 ms steps, retries by one
// RULE_18 - Self-synchronous x^43+1 scrambling and descrambling
// RULE_19 - Scramble most significant bit first
// RULE_20 - Scramble high-order paths, not low-order
// RULE_21 - Path label 18, 16 or CF
// RULE_22 - Upper data carries six-bit class code
// RULE_23 - Flag delimiting and octet escaping both ways
// RULE_24 - Address octet 0x04 after opening flag
// RULE_25 - Control octet 0x03, others reserved
// RULE_26 - CRC-32, preset ones, complemented remainder
// RULE_27 - Descrambler keeps 43-bit line history
// RULE_28 - Any received octet restarts the monitor
module lpf_framer #(
  parameter AW = 11,
  parameter TICK_CYC = `LPF_TICK_CYC
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [3:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  input wire i_tx_valid,
  input wire [7:0] i_tx_data,
  input wire i_tx_last,
  input wire i_tx_ipv6,
  input wire [5:0] i_tx_class,
  output reg o_tx_ready,
  input wire i_line_tx_req,
  output wire o_line_tx_valid,
  output wire [7:0] o_line_tx_data,
  output reg [5:0] o_line_tx_class,
  input wire i_line_rx_valid,
  input wire [7:0] i_line_rx_data,
  output reg o_rx_valid,
  output reg [7:0] o_rx_data,
  output reg o_rx_last,
  output reg o_rx_ipv6,
  output reg [7:0] o_path_label,
  output wire o_link_loss
);
  // ****************************************************************
  // Shared arithmetic
  // ****************************************************************
  function [31:0] crc_byte;
    input [31:0] crc;
    input [7:0] data;
    integer k;
    reg [31:0] c;
    begin
      c = crc ^ {24'h000000, data};
      for (k = 0; k < 8; k = k + 1)
        c = c[0] ? ((c >> 1) ^ `LPF_CRC_POLY) : (c >> 1); // RULE_26
      crc_byte = c;
    end
  endfunction

  function needs_esc;
    input [7:0] b;
    begin
      needs_esc = (b == `LPF_FLAG) || (b == `LPF_ESC); // RULE_23
    end
  endfunction

  // ****************************************************************
  // Register port
  // ****************************************************************
  reg [4:0] ctrl_q;
  reg [7:0] timer_q;
  reg [7:0] retry_q;
  reg [15:0] good_q;
  reg [15:0] drop_q;
  reg loss_seen_q;
  wire scr_bypass;
  wire [1:0] label_mode = ctrl_q[`LPF_CTRL_MODE_LSB+1:`LPF_CTRL_MODE_LSB];
  // Plain mode carries no scrambling, and low-order paths need none.
  assign scr_bypass = !ctrl_q[`LPF_CTRL_SCR_BIT] ||
                      ctrl_q[`LPF_CTRL_LOWVC_BIT] || (label_mode == 2'h2);

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= `LPF_CTRL_RST;
      timer_q <= `LPF_TIMER_RST; // RULE_14
      retry_q <= `LPF_RETRY_RST;
      loss_seen_q <= 1'b0;
      o_reg_rdata <= 32'h00000000;
      o_path_label <= `LPF_LABEL_SCR;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == `LPF_REG_CTRL)
        ctrl_q <= i_reg_wdata[4:0];
      if (i_reg_wr && i_reg_addr == `LPF_REG_TIMER)
        timer_q <= i_reg_wdata[7:0]; // RULE_17
      if (i_reg_wr && i_reg_addr == `LPF_REG_RETRY)
        retry_q <= i_reg_wdata[7:0];
      // A loss in the same cycle as the clear wins.
      if (o_link_loss)
        loss_seen_q <= 1'b1;
      else if (i_reg_wr && i_reg_addr == `LPF_REG_STATUS && i_reg_wdata[0])
        loss_seen_q <= 1'b0;
      case (label_mode)
        2'h1: o_path_label <= `LPF_LABEL_COMPAT; // RULE_21
        2'h2: o_path_label <= `LPF_LABEL_PLAIN;
        default: o_path_label <= `LPF_LABEL_SCR;
      endcase
      o_reg_rdata <= 32'h00000000;
      if (i_reg_rd)
        case (i_reg_addr)
          `LPF_REG_CTRL: o_reg_rdata <= {27'h0000000, ctrl_q};
          `LPF_REG_TIMER: o_reg_rdata <= {24'h000000, timer_q};
          `LPF_REG_RETRY: o_reg_rdata <= {24'h000000, retry_q};
          `LPF_REG_STATUS: o_reg_rdata <= {31'h00000000, loss_seen_q};
          `LPF_REG_GOOD: o_reg_rdata <= {16'h0000, good_q};
          `LPF_REG_DROP: o_reg_rdata <= {16'h0000, drop_q};
          `LPF_REG_LABEL: o_reg_rdata <= {24'h000000, o_path_label};
          default: o_reg_rdata <= 32'h00000000;
        endcase
    end
  end

  // ****************************************************************
  // Transmit framing
  // ****************************************************************
  localparam [7:0] T_IDLE = 8'h01, T_ADDR = 8'h02, T_CTRL = 8'h04,
    T_SPH = 8'h08, T_SPL = 8'h10, T_DATA = 8'h20, T_FCS = 8'h40,
    T_CLOSE = 8'h80;
  reg [7:0] tx_st_q;
  reg [7:0] hold_data_q;
  reg hold_v_q;
  reg hold_last_q;
  reg hold_v6_q;
  reg [5:0] hold_class_q;
  reg tx_v6_q;
  reg [31:0] tx_crc_q;
  reg [1:0] fcs_idx_q;
  reg esc_pend_q;
  reg [7:0] esc_byte_q;
  reg [7:0] raw_d;
  reg [7:0] tx_next_d;
  reg take_hold;
  reg tx_crc_upd;
  wire hold_load = i_tx_valid && o_tx_ready;
  wire tx_step = i_line_tx_req && !esc_pend_q;
  wire hold_v_next = (hold_v_q && !(tx_step && take_hold)) || hold_load;
  wire [31:0] fcs_val = ~tx_crc_q;

  always @*
  begin
    raw_d = `LPF_FLAG;
    tx_next_d = tx_st_q;
    take_hold = 1'b0;
    tx_crc_upd = 1'b0;
    case (tx_st_q)
      T_IDLE:
        if (hold_v_q)
          tx_next_d = T_ADDR;
      T_ADDR:
      begin
        raw_d = `LPF_ADDR; // RULE_24
        tx_crc_upd = 1'b1;
        tx_next_d = T_CTRL;
      end
      T_CTRL:
      begin
        raw_d = `LPF_CTRL_UI; // RULE_25
        tx_crc_upd = 1'b1;
        tx_next_d = T_SPH;
      end
      T_SPH:
      begin
        raw_d = `LPF_SPI_HI; // RULE_10 RULE_02
        tx_crc_upd = 1'b1;
        tx_next_d = T_SPL;
      end
      T_SPL:
      begin
        raw_d = tx_v6_q ? `LPF_SPI_V6 : `LPF_SPI_V4; // RULE_11
        tx_crc_upd = 1'b1;
        tx_next_d = T_DATA;
      end
      T_DATA:
        if (hold_v_q)
        begin
          raw_d = hold_data_q; // RULE_12 RULE_01
          take_hold = 1'b1;
          tx_crc_upd = 1'b1;
          if (hold_last_q)
            tx_next_d = T_FCS;
        end
        else
          tx_next_d = T_IDLE; // Underrun sends the flag octet escaped (7D 5E), then returns to idle.
      T_FCS:
      begin
        raw_d = fcs_val[8*fcs_idx_q +: 8]; // RULE_03
        if (fcs_idx_q == 2'h3)
          tx_next_d = T_CLOSE;
      end
      T_CLOSE:
        tx_next_d = T_IDLE;
      default:
        tx_next_d = T_IDLE;
    endcase
  end

  wire raw_esc = tx_st_q != T_IDLE && tx_st_q != T_CLOSE && needs_esc(raw_d);
  wire [7:0] line_byte = esc_pend_q ? esc_byte_q :
                         (raw_esc ? `LPF_ESC : raw_d);

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_st_q <= T_IDLE;
      hold_v_q <= 1'b0;
      hold_data_q <= 8'h00;
      hold_last_q <= 1'b0;
      hold_v6_q <= 1'b0;
      hold_class_q <= 6'h00;
      tx_v6_q <= 1'b0;
      tx_crc_q <= `LPF_CRC_INIT;
      fcs_idx_q <= 2'h0;
      esc_pend_q <= 1'b0;
      esc_byte_q <= 8'h00;
      o_tx_ready <= 1'b0;
      o_line_tx_class <= 6'h00;
    end
    else
    begin
      o_tx_ready <= !hold_v_next;
      if (hold_load)
      begin
        hold_v_q <= 1'b1;
        hold_data_q <= i_tx_data;
        hold_last_q <= i_tx_last;
        hold_v6_q <= i_tx_ipv6;
        hold_class_q <= i_tx_class; // RULE_22
      end
      else if (tx_step && take_hold)
        hold_v_q <= 1'b0;
      if (i_line_tx_req && esc_pend_q)
        esc_pend_q <= 1'b0;
      if (tx_step)
      begin
        tx_st_q <= tx_next_d;
        if (raw_esc)
        begin
          esc_pend_q <= 1'b1;
          esc_byte_q <= raw_d ^ `LPF_ESC_XOR; // RULE_23
        end
        if (tx_st_q == T_IDLE)
        begin
          tx_v6_q <= hold_v6_q;
          o_line_tx_class <= hold_class_q;
          tx_crc_q <= `LPF_CRC_INIT;
          fcs_idx_q <= 2'h0;
        end
        if (tx_crc_upd)
          tx_crc_q <= crc_byte(tx_crc_q, raw_d);
        if (tx_st_q == T_FCS)
          fcs_idx_q <= fcs_idx_q + 2'h1;
      end
    end
  end

  lpf_scrambler #(.DESCR(0)) u_scr (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_en(i_line_tx_req),
    .i_bypass(scr_bypass),
    .i_data(line_byte),
    .o_valid(o_line_tx_valid),
    .o_data(o_line_tx_data)
  );

  // ****************************************************************
  // Receive validation and delivery
  // ****************************************************************
  wire rx_v;
  wire [7:0] rx_b;
  lpf_scrambler #(.DESCR(1)) u_dscr (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_en(i_line_rx_valid),
    .i_bypass(scr_bypass),
    .i_data(i_line_rx_data),
    .o_valid(rx_v),
    .o_data(rx_b)
  );

  // Whole frames are held until the check sequence proves them good.
  reg [9:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] start_q;
  reg [AW-1:0] commit_q;
  reg [AW-1:0] rd_q;
  reg in_frame_q;
  reg esc_q;
  reg bad_q;
  reg [15:0] cnt_q;
  reg [31:0] rx_crc_q;
  reg [7:0] addr_q;
  reg [7:0] ctl_q;
  reg [15:0] spi_q;
  reg [31:0] dly_q;
  reg [7:0] last_b_q;
  wire is_flag = rx_b == `LPF_FLAG;
  wire [7:0] rx_dat = esc_q ? (rx_b ^ `LPF_ESC_XOR) : rx_b; // RULE_23
  wire spi_ok = spi_q == {`LPF_SPI_HI, `LPF_SPI_V4} ||
                spi_q == {`LPF_SPI_HI, `LPF_SPI_V6}; // RULE_07 RULE_11
  wire frame_ok = !bad_q && !esc_q && cnt_q >= `LPF_MIN_OCTETS && // RULE_05
                  rx_crc_q == `LPF_CRC_GOOD && // RULE_06
                  addr_q == `LPF_ADDR && ctl_q == `LPF_CTRL_UI && // RULE_08
                  spi_ok;
  wire full = (wr_q + {{(AW-1){1'b0}}, 1'b1}) == rd_q;
  wire rx_dat_v = rx_v && in_frame_q && !is_flag && rx_b != `LPF_ESC;

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_q <= {AW{1'b0}};
      start_q <= {AW{1'b0}};
      commit_q <= {AW{1'b0}};
      in_frame_q <= 1'b0;
      esc_q <= 1'b0;
      bad_q <= 1'b0;
      cnt_q <= 16'h0000;
      rx_crc_q <= `LPF_CRC_INIT;
      addr_q <= 8'h00;
      ctl_q <= 8'h00;
      spi_q <= 16'h0000;
      dly_q <= 32'h00000000;
      last_b_q <= 8'h00;
      good_q <= 16'h0000;
      drop_q <= 16'h0000;
    end
    else if (rx_v)
    begin
      if (is_flag)
      begin
        // Octets before the first flag never form a frame.
        in_frame_q <= 1'b1; // RULE_04
        esc_q <= 1'b0;
        bad_q <= 1'b0;
        cnt_q <= 16'h0000;
        rx_crc_q <= `LPF_CRC_INIT;
        if (in_frame_q && cnt_q != 16'h0000)
        begin
          if (frame_ok)
          begin
            if (cnt_q > 16'h0008)
            begin
              mem[wr_q - {{(AW-1){1'b0}}, 1'b1}] <=
                {spi_q[7:0] == `LPF_SPI_V6, 1'b1, last_b_q}; // RULE_13
              commit_q <= wr_q;
              start_q <= wr_q;
            end
            good_q <= good_q + 16'h0001;
          end
          else
          begin
            wr_q <= start_q; // RULE_09
            drop_q <= drop_q + 16'h0001;
          end
        end
        else
          wr_q <= start_q;
      end
      else if (in_frame_q && rx_b == `LPF_ESC && !esc_q)
        esc_q <= 1'b1;
      else if (rx_dat_v || (in_frame_q && esc_q))
      begin
        esc_q <= 1'b0;
        if (cnt_q != 16'hFFFF)
          cnt_q <= cnt_q + 16'h0001;
        rx_crc_q <= crc_byte(rx_crc_q, rx_dat);
        case (cnt_q)
          16'h0000: addr_q <= rx_dat;
          16'h0001: ctl_q <= rx_dat;
          16'h0002: spi_q[15:8] <= rx_dat; // RULE_02
          16'h0003: spi_q[7:0] <= rx_dat;
          default:
          begin
            // The last four octets are the check sequence, not payload.
            dly_q <= {dly_q[23:0], rx_dat};
            if (cnt_q >= 16'h0008)
            begin
              if (full)
                bad_q <= 1'b1;
              else
              begin
                mem[wr_q] <= {spi_q[7:0] == `LPF_SPI_V6, 1'b0, dly_q[31:24]};
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
                last_b_q <= dly_q[31:24];
              end
            end
          end
        endcase
      end
    end
  end

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_q <= {AW{1'b0}};
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_last <= 1'b0;
      o_rx_ipv6 <= 1'b0;
    end
    else
    begin
      o_rx_valid <= rd_q != commit_q;
      if (rd_q != commit_q)
      begin
        {o_rx_ipv6, o_rx_last, o_rx_data} <= mem[rd_q];
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      else
        o_rx_last <= 1'b0;
    end
  end

  // ****************************************************************
  // Idle-link monitor
  // ****************************************************************
  lpf_silence_mon #(.TICK_CYC(TICK_CYC)) u_mon (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_enable(ctrl_q[`LPF_CTRL_MON_BIT]),
    .i_activity(i_line_rx_valid), // RULE_28
    .i_period(timer_q),
    .i_retries(retry_q),
    .o_link_loss(o_link_loss)
  );
endmodule
`default_nettype wire

// ==== verification/lpf_line_model.sv ====
/* Line side partner: a path framer that pulls octets and can loop them back
   or inject bench octets. Assumes one clock shared with the framer. */
`timescale 1ns/1ps
`default_nettype none
module lpf_line_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_loop,
  input wire logic i_slow,
  input wire logic i_inj_valid,
  input wire logic [7:0] i_inj_data,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_req,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data
);
  logic fwd;
  assign fwd = i_loop & i_tx_valid;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end
    else
    begin
      // A slow framer pulls only every other cycle.
      o_req <= i_slow ? ~o_req : 1'b1;
      o_rx_valid <= i_inj_valid | fwd;
      // Idle data toggles so a stale octet is never mistaken for fresh.
      if (i_inj_valid)
        o_rx_data <= i_inj_data;
      else if (fwd)
        o_rx_data <= i_tx_data;
      else
        o_rx_data <= ~o_rx_data;
    end
  end
endmodule
`default_nettype wire

// ==== verification/lpf_framer_asserts.sv ====
/* Port checker of the link framer, bound to its top module.
   Assumes one clock and the active high reset of the framer. */
`timescale 1ns/1ps
`default_nettype none
module lpf_framer_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic i_line_tx_req,
  input wire logic o_line_tx_valid,
  input wire logic i_line_rx_valid,
  input wire logic o_rx_valid,
  input wire logic o_rx_last,
  input wire logic [7:0] o_path_label,
  input wire logic o_link_loss
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_LINE_ANSWER: assert property (i_line_tx_req |=> o_line_tx_valid)
    else $error("line octet missing");
  AST_LINE_QUIET: assert property (!i_line_tx_req |=> !o_line_tx_valid)
    else $error("line octet without request");
  AST_TX_TAKE: assert property (i_tx_valid && o_tx_ready |=> !o_tx_ready)
    else $error("ready stayed after take");
  AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("read data without read");
  AST_LABEL_CODE: assert property (o_path_label == 8'h18 ||
    o_path_label == 8'h16 || o_path_label == 8'hCF) else $error("bad label");
  AST_LABEL_HOLD: assert property (!i_reg_wr ##1 !i_reg_wr |=>
    $stable(o_path_label)) else $error("label moved without write");
  AST_LOSS_PULSE: assert property (o_link_loss |=> !o_link_loss)
    else $error("loss longer than a cycle");
  AST_LOSS_QUIET: assert property (i_line_rx_valid |-> ##2 !o_link_loss)
    else $error("loss despite activity");
  AST_RX_LAST: assert property (o_rx_last |-> o_rx_valid)
    else $error("last without valid");
endmodule
bind lpf_framer lpf_framer_asserts u_chk (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_tx_valid(i_tx_valid),
  .o_tx_ready(o_tx_ready), .i_line_tx_req(i_line_tx_req),
  .o_line_tx_valid(o_line_tx_valid), .i_line_rx_valid(i_line_rx_valid),
  .o_rx_valid(o_rx_valid), .o_rx_last(o_rx_last),
  .o_path_label(o_path_label), .o_link_loss(o_link_loss));
`default_nettype wire

// ==== verification/lpf_framer_tb_top.sv ====
/* Self-checking bench of the link framer: registers, frames both ways,
   drops, path label and idle monitor. Assumes the line model and checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  err_count++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module lpf_framer_tb_top;
  // ********
  // Bench state
  // ********
  localparam int TICK = 10;
  typedef struct packed {logic [7:0] a, c, s; logic bad, ok;} lpf_row_t;
  lpf_row_t rows[6] = '{'{8'h04, 8'h03, 8'h21, 1'b0, 1'b1},
    '{8'h04, 8'h03, 8'h57, 1'b0, 1'b1}, '{8'h05, 8'h03, 8'h21, 1'b0, 1'b0},
    '{8'h04, 8'h13, 8'h21, 1'b0, 1'b0}, '{8'h04, 8'h03, 8'h23, 1'b0, 1'b0},
    '{8'h04, 8'h03, 8'h21, 1'b1, 1'b0}};
  logic [35:0] regs[6] = '{{4'h0, 32'h11}, {4'h1, 32'h0A}, {4'h2, 32'h3},
    {4'h3, 32'h0}, {4'h6, 32'h18}, {4'h9, 32'h0}};
  logic [7:0] lbls[3] = '{8'h18, 8'h16, 8'hCF};
  int err_count = 0;
  int cmp_count = 0;
  logic clk = 0, rst = 1, wr = 0, rd = 0, tx_v = 0, tx_l = 0, tx_6 = 0;
  logic loop = 0, slow = 0, inj_v = 0;
  logic [3:0] ra = 0;
  logic [31:0] wd = 0, rdat, v, g, x;
  logic [7:0] tx_d = 0, inj_d = 0, ltd, lrd, rdd, lbl;
  logic [5:0] tx_c = 0, lcls;
  logic rdy, req, ltv, lrv, rv, rl, r6, loss;
  logic [7:0] body[$], line[$], info[$], txq[$], rxq[$];
  logic lastq[$], ipq[$];
  always #2.5 clk = ~clk;
  lpf_framer #(.TICK_CYC(TICK)) DUT (.i_clk_sys(clk), .i_rst(rst),
    .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdat), .i_tx_valid(tx_v), .i_tx_data(tx_d),
    .i_tx_last(tx_l), .i_tx_ipv6(tx_6), .i_tx_class(tx_c), .o_tx_ready(rdy),
    .i_line_tx_req(req), .o_line_tx_valid(ltv), .o_line_tx_data(ltd),
    .o_line_tx_class(lcls), .i_line_rx_valid(lrv), .i_line_rx_data(lrd),
    .o_rx_valid(rv), .o_rx_data(rdd), .o_rx_last(rl), .o_rx_ipv6(r6),
    .o_path_label(lbl), .o_link_loss(loss));
  lpf_line_model PEER (.i_clk_sys(clk), .i_rst(rst), .i_loop(loop),
    .i_slow(slow), .i_inj_valid(inj_v), .i_inj_data(inj_d),
    .i_tx_valid(ltv), .i_tx_data(ltd), .o_req(req), .o_rx_valid(lrv),
    .o_rx_data(lrd));
  always @(posedge clk)
  begin
    if (ltv === 1'b1)
      txq.push_back(ltd);
    if (rv === 1'b1)
    begin
      rxq.push_back(rdd);
      lastq.push_back(rl);
      ipq.push_back(r6);
    end
  end
  // ********
  // Tasks
  // ********
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic mk_line(input logic [7:0] a, c, s, input logic bad);
    logic [31:0] crc;
    crc = 32'hFFFFFFFF;
    body = {a, c, 8'h00, s};
    body = {body, info};
    foreach (body[i])
      for (int k = 0; k < 8; k++)
        crc = (crc >> 1) ^ ((crc[0] ^ body[i][k]) ? 32'hEDB88320 : 32'h0);
    crc = ~crc ^ {31'h0, bad};
    for (int k = 0; k < 4; k++)
      body.push_back(crc[8*k +: 8]);
    line = {8'h7E};
    foreach (body[i])
      if (body[i] == 8'h7E || body[i] == 8'h7D)
        line = {line, 8'h7D, body[i] ^ 8'h20};
      else
        line.push_back(body[i]);
    line.push_back(8'h7E);
  endtask
  task automatic inject();
    foreach (line[i])
    begin
      @(posedge clk);
      inj_v <= 1'b1;
      inj_d <= line[i];
    end
    @(posedge clk);
    inj_v <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic send(input logic v6, input logic [5:0] cl);
    foreach (info[i])
    begin
      tx_v <= 1'b1;
      tx_d <= info[i];
      tx_l <= (i == info.size() - 1);
      tx_6 <= v6;
      tx_c <= cl;
      do @(posedge clk); while (rdy !== 1'b1);
    end
    tx_v <= 1'b0;
  endtask
  task automatic check_rx(input logic v6);
    `CHK("rx count", info.size(), rxq.size())
    foreach (info[i])
    begin
      `CHK("rx data", info[i], rxq[i])
      `CHK("rx last", (i == info.size() - 1), lastq[i])
      `CHK("rx ipv6", v6, ipq[i])
    end
    rxq = {};
    lastq = {};
    ipq = {};
  endtask
  task automatic check_tx();
    info = {8'h7E, 8'h7D, 8'h41};
    mk_line(8'h04, 8'h03, 8'h21, 1'b0);
    txq = {};
    send(1'b0, 6'h2A);
    `CHK("class", 6'h2A, lcls)
    repeat (40) @(posedge clk);
    while (txq.size() > 0 && txq[0] === 8'h7E)
      void'(txq.pop_front());
    for (int i = 1; i < line.size(); i++)
      `CHK("line octet", line[i], txq[i - 1])
  endtask
  task automatic loss_gap(input int exp);
    int n;
    n = 1;
    while (loss !== 1'b1) @(posedge clk);
    @(posedge clk);
    while (loss !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("loss gap", exp, n)
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK("ready", 1'b1, rdy)
    foreach (regs[i])
    begin
      reg_rd(regs[i][35:32], v);
      `CHK("reg reset", regs[i][31:0], v)
    end
    // Scrambling off so injected octets reach the checks as written.
    reg_wr(4'h0, 32'h10);
    info = {8'hAA};
    mk_line(8'h04, 8'h03, 8'h21, 1'b0);
    void'(line.pop_front());
    inject();
    info = {};
    check_rx(1'b0);
    reg_rd(4'h5, v);
    reg_rd(4'h4, g);
    foreach (rows[i])
    begin
      info = {8'h7E, 8'h7D, 8'hA5};
      mk_line(rows[i].a, rows[i].c, rows[i].s, rows[i].bad);
      inject();
      if (!rows[i].ok)
        info = {};
      check_rx(rows[i].s == 8'h57);
    end
    info = {8'h55};
    mk_line(8'h04, 8'h03, 8'h21, 1'b0);
    line[line.size() - 1] = 8'h7D;
    line.push_back(8'h7E);
    inject();
    info = {};
    check_rx(1'b0);
    line = {8'h7E, 8'h04, 8'h03, 8'h00, 8'h21, 8'h7E};
    inject();
    check_rx(1'b0);
    reg_rd(4'h5, x);
    `CHK("drops", v + 32'h6, x)
    reg_rd(4'h4, x);
    `CHK("goods", g + 32'h2, x)
    for (int m = 0; m < 3; m++)
    begin
      reg_wr(4'h0, {27'h0, 1'b1, m[1:0], 2'b01});
      repeat (2) @(posedge clk);
      `CHK("label", lbls[m], lbl)
    end
    check_tx();
    reg_wr(4'h0, 32'h13);
    check_tx();
    reg_wr(4'h0, 32'h11);
    loop <= 1'b1;
    slow <= 1'b1;
    repeat (30) @(posedge clk);
    info = {8'h7E, 8'h11, 8'h22};
    send(1'b1, 6'h01);
    repeat (80) @(posedge clk);
    check_rx(1'b1);
    loop <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    loss_gap(4 * 10 * TICK);
    reg_wr(4'h1, 32'h2);
    reg_wr(4'h2, 32'h0);
    line = {8'h7E};
    inject();
    loss_gap(2 * TICK);
    complete_run();
  end
  initial
  begin
    #40000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
